/* rtl/sbx_params.svh */
// Notes on behaviour
// - the low-power entry instruction clears the power-down flag.
// - the low-power entry instruction sets the time-out flag.
// - the low-power entry instruction zeroes the watchdog counter and postscaler.
// - after the last quarter-cycle the core sleeps with its oscillator halted.
// - a watchdog time-out that wakes the core clears the time-out flag.
// - borrow-subtract computes work minus file minus inverted carry.
// - destination bit 0 writes the work register, 1 writes the file.
// - bank bit 0 uses the access bank, 1 uses the bank select register.
// - extended set, bank bit 0 and file address up to 95 use indexed offset.
//
// constants shared by the execution core and its package
// assumes a single core clock; all offsets are register-port addresses
`ifndef SBX_PARAMS_SVH
`define SBX_PARAMS_SVH

// ==========================================================
// widths
`define SBX_DATA_W 8
`define SBX_INSTR_W 16
`define SBX_ADDR_W 13
`define SBX_FILE_AW 12
`define SBX_FILE_DEPTH 4096
`define SBX_BANK_W 4
`define SBX_WDOG_POST_W 4
`define SBX_WDOG_CNT_W 8

// ==========================================================
// register port map
`define SBX_FILE_SEL_BIT 12
`define SBX_REG_CTRL 13'h0000
`define SBX_REG_BANK 13'h0001
`define SBX_REG_WORK 13'h0002
`define SBX_REG_STATUS 13'h0003
`define SBX_REG_WDOG 13'h0004
`define SBX_REG_IDXL 13'h0005
`define SBX_REG_IDXH 13'h0006
`define SBX_CTRL_EXT_BIT 0
`define SBX_CTRL_WDOG_EN_BIT 1
`define SBX_STAT_FLAGS_MSB 4
`define SBX_STAT_POWER_DOWN_BIT 5
`define SBX_STAT_TIMEOUT_BIT 6
`define SBX_STAT_SLEEPING_BIT 7

// ==========================================================
// reset values
`define SBX_RST_BYTE 8'h00
`define SBX_RST_BANK 4'h0
`define SBX_RST_INDEX 12'h000
`define SBX_RST_TIMEOUT_FLAG 1'b1
`define SBX_RST_POWER_DOWN_FLAG 1'b1

// ==========================================================
// instruction encoding
`define SBX_OPC_SLEEP 16'h0003
`define SBX_OPC_SUBB_HI 6'h15
`define SBX_OPC_HI_MSB 15
`define SBX_OPC_HI_LSB 10
`define SBX_INSTR_D_BIT 9
`define SBX_INSTR_A_BIT 8
`define SBX_INSTR_F_MSB 7
`define SBX_IDX_LIMIT 8'h5f
`define SBX_ACC_LOW_BANK 4'h0
`define SBX_ACC_HIGH_BANK 4'hf

`endif

/* rtl/sbx_pkg.sv */
// types for the sleep and borrow-subtract execution core
// assumes sbx_params.svh supplies the widths
`include "sbx_params.svh"
`default_nettype none

package sbx_pkg;

    // ==========================================================
    // quarter-cycle sequencer
    typedef enum logic [2:0] {
        SBX_IDLE = 3'b000,
        SBX_Q2 = 3'b001,
        SBX_Q3 = 3'b010,
        SBX_Q4 = 3'b011,
        SBX_SLEEP = 3'b100
    } sbx_state_t;

    typedef enum logic [1:0] {
        SBX_OP_NONE = 2'b00,
        SBX_OP_SLEEP = 2'b01,
        SBX_OP_SUBTRACT_FILE_FROM_WORK_WITH_BORROW = 2'b10
    } sbx_op_t;

    // ==========================================================
    // carriers; field order matches the status byte, msb first
    typedef struct packed {
        logic negative;
        logic overflowFlag;
        logic zero;
        logic digitCarryFlag;
        logic carry;
    } sbx_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`SBX_ADDR_W-1:0] addr;
        logic [`SBX_DATA_W-1:0] wdata;
    } sbx_bus_req_t;

endpackage : sbx_pkg

`default_nettype wire

/* rtl/sbx_sub_borrow_alu.sv */
// combinational work-minus-file-minus-borrow datapath
// assumes the caller registers the result and flags
`include "sbx_params.svh"
`default_nettype none

module sbx_sub_borrow_alu (
    input wire logic [`SBX_DATA_W-1:0] workIn, // work register
    input wire logic [`SBX_DATA_W-1:0] fileIn, // file operand
    input wire logic carryIn, // carry, low means borrow
    output logic [`SBX_DATA_W-1:0] result, // difference
    output sbx_pkg::sbx_flags_t flags // flags of the difference
);

    logic [`SBX_DATA_W:0] fullSum;
    logic [4:0] lowSum;

    // subtract as add of the complement plus carry, so carry is not-borrow
    always_comb begin
        fullSum = {1'b0, workIn} + {1'b0, ~fileIn} +
            {{`SBX_DATA_W{1'b0}}, carryIn};
        lowSum = {1'b0, workIn[3:0]} + {1'b0, ~fileIn[3:0]} +
            {4'h0, carryIn};
        result = fullSum[`SBX_DATA_W-1:0];
        flags.carry = fullSum[`SBX_DATA_W];
        flags.digitCarryFlag = lowSum[4];
        flags.zero = (fullSum[`SBX_DATA_W-1:0] == '0);
        flags.negative = fullSum[`SBX_DATA_W-1];
        flags.overflowFlag = (workIn[`SBX_DATA_W-1] != fileIn[`SBX_DATA_W-1])
            && (fullSum[`SBX_DATA_W-1] != workIn[`SBX_DATA_W-1]);
    end

endmodule : sbx_sub_borrow_alu

`default_nettype wire

/* rtl/sbx_watchdog.sv */
// watchdog counter with postscaler and a one-cycle time-out pulse
// assumes it keeps running while the core oscillator is halted
`include "sbx_params.svh"
`default_nettype none

module sbx_watchdog #(
    parameter int POST_W = `SBX_WDOG_POST_W, // postscaler width
    parameter int CNT_W = `SBX_WDOG_CNT_W // counter width
) (
    input wire logic clk, // watchdog clock
    input wire logic rst_n, // async reset, active low
    input wire logic enable, // count while high
    input wire logic clear, // zero counter and postscaler
    output logic [CNT_W-1:0] count, // counter value
    output logic [POST_W-1:0] postscale, // postscaler value
    output logic timeout // one-cycle pulse at wrap
);

    logic [POST_W-1:0] postReg;
    logic [POST_W-1:0] postNext;
    logic [CNT_W-1:0] cntReg;
    logic [CNT_W-1:0] cntNext;
    logic timeoutReg;
    logic timeoutNext;

    // ==========================================================
    // counting
    always_comb begin
        postNext = postReg;
        cntNext = cntReg;
        timeoutNext = 1'b0;
        if (clear) begin
            postNext = '0;
            cntNext = '0;
        end else if (enable) begin
            postNext = POST_W'(postReg + 1'b1);
            if (postReg == '1) begin
                if (cntReg == '1) begin
                    cntNext = '0;
                    timeoutNext = 1'b1;
                end else begin
                    cntNext = CNT_W'(cntReg + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            postReg <= '0;
            cntReg <= '0;
            timeoutReg <= 1'b0;
        end else begin
            postReg <= postNext;
            cntReg <= cntNext;
            timeoutReg <= timeoutNext;
        end
    end

    assign count = cntReg;
    assign postscale = postReg;
    assign timeout = timeoutReg;

endmodule : sbx_watchdog

`default_nettype wire

/* rtl/sbx_exec.sv */
// execution core for the low-power entry and borrow-subtract instructions
// assumes one core clock, instructions offered by same-clock logic,
// and a wake pin that is asynchronous to the core clock
//
// Design decisions made here: strobed register access and the register offsets.
`include "sbx_params.svh"
`default_nettype none

module sbx_exec #(
    parameter int WDOG_POST_W = `SBX_WDOG_POST_W, // postscaler width
    parameter int WDOG_CNT_W = `SBX_WDOG_CNT_W // counter width, 8 at most
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic instrValid, // instruction offered
    input wire logic [`SBX_INSTR_W-1:0] instrWord, // instruction word
    output logic instrReady, // core takes an instruction
    output logic retired, // pulse after the fourth quarter
    input wire sbx_pkg::sbx_bus_req_t busReq, // register port request
    output logic [`SBX_DATA_W-1:0] busRdata, // read data, next cycle
    input wire logic wakePin, // external wake, asynchronous
    output logic sleeping, // core is in the low-power state
    output logic oscRunning // core oscillator enable
);

    // ==========================================================
    // state
    sbx_pkg::sbx_state_t stateReg;
    sbx_pkg::sbx_state_t stateNext;
    sbx_pkg::sbx_op_t opReg;
    sbx_pkg::sbx_op_t opNext;
    sbx_pkg::sbx_op_t decodedOp;
    logic [`SBX_FILE_AW-1:0] fileAddrReg;
    logic [`SBX_FILE_AW-1:0] fileAddrNext;
    logic [`SBX_FILE_AW-1:0] effAddr;
    logic destFileReg;
    logic destFileNext;
    logic [`SBX_DATA_W-1:0] operandReg;
    logic [`SBX_DATA_W-1:0] operandNext;
    logic [`SBX_DATA_W-1:0] resultReg;
    logic [`SBX_DATA_W-1:0] resultNext;
    sbx_pkg::sbx_flags_t resFlagsReg;
    sbx_pkg::sbx_flags_t resFlagsNext;
    logic [`SBX_DATA_W-1:0] workReg;
    logic [`SBX_DATA_W-1:0] workNext;
    logic [`SBX_BANK_W-1:0] bankSelectRegisterReg;
    logic [`SBX_BANK_W-1:0] bankSelectRegisterNext;
    logic [`SBX_DATA_W-1:0] ctrlReg;
    logic [`SBX_DATA_W-1:0] ctrlNext;
    logic [`SBX_FILE_AW-1:0] indexBaseReg;
    logic [`SBX_FILE_AW-1:0] indexBaseNext;
    sbx_pkg::sbx_flags_t flagsReg;
    sbx_pkg::sbx_flags_t flagsNext;
    logic timeoutFlagReg;
    logic timeoutFlagNext;
    logic powerDownFlagReg;
    logic powerDownFlagNext;
    logic sleepingReg;
    logic sleepingNext;
    logic retiredReg;
    logic retiredNext;
    logic [`SBX_DATA_W-1:0] rdataReg;
    logic [`SBX_DATA_W-1:0] rdataNext;
    logic [`SBX_DATA_W-1:0] statusByte;

    logic wakeS1Reg;
    logic wakeS2Reg;
    logic wakeS3Reg;
    logic wakeLevelReg;
    logic wakeLevelNext;

    logic [`SBX_DATA_W-1:0] fileMem [0:`SBX_FILE_DEPTH-1];
    logic memWe;
    logic [`SBX_FILE_AW-1:0] memAddr;
    logic [`SBX_DATA_W-1:0] memData;

    logic [`SBX_DATA_W-1:0] aluResult;
    sbx_pkg::sbx_flags_t aluFlags;
    logic watchdogClear;
    logic watchdogTimeout;
    logic [WDOG_CNT_W-1:0] watchdogCounter;

    // ==========================================================
    // datapath and watchdog
    sbx_sub_borrow_alu u_alu (
        .workIn(workReg),
        .fileIn(operandReg),
        .carryIn(flagsReg.carry),
        .result(aluResult),
        .flags(aluFlags)
    );

    // the watchdog keeps counting in sleep so that it can wake the core
    sbx_watchdog #(
        .POST_W(WDOG_POST_W),
        .CNT_W(WDOG_CNT_W)
    ) u_watchdog (
        .clk(clk),
        .rst_n(rst_n),
        .enable(ctrlReg[`SBX_CTRL_WDOG_EN_BIT]),
        .clear(watchdogClear),
        .count(watchdogCounter),
        .postscale(),
        .timeout(watchdogTimeout)
    );

    // ==========================================================
    // wake pin synchroniser
    always_comb begin
        wakeLevelNext = wakeLevelReg;
        if (wakeS2Reg == wakeS3Reg) begin
            wakeLevelNext = wakeS3Reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeS1Reg <= 1'b0;
            wakeS2Reg <= 1'b0;
            wakeS3Reg <= 1'b0;
            wakeLevelReg <= 1'b0;
        end else begin
            wakeS1Reg <= wakePin;
            wakeS2Reg <= wakeS1Reg;
            wakeS3Reg <= wakeS2Reg;
            wakeLevelReg <= wakeLevelNext;
        end
    end

    // ==========================================================
    // decode and effective address
    always_comb begin
        decodedOp = sbx_pkg::SBX_OP_NONE;
        if (instrWord == `SBX_OPC_SLEEP) begin
            decodedOp = sbx_pkg::SBX_OP_SLEEP;
        end else if (instrWord[`SBX_OPC_HI_MSB:`SBX_OPC_HI_LSB] ==
                     `SBX_OPC_SUBB_HI) begin
            decodedOp =
                sbx_pkg::SBX_OP_SUBTRACT_FILE_FROM_WORK_WITH_BORROW;
        end
        if (instrWord[`SBX_INSTR_A_BIT]) begin
            effAddr = {bankSelectRegisterReg,
                       instrWord[`SBX_INSTR_F_MSB:0]};
        end else if (ctrlReg[`SBX_CTRL_EXT_BIT] &&
                     instrWord[`SBX_INSTR_F_MSB:0] <= `SBX_IDX_LIMIT) begin
            effAddr = `SBX_FILE_AW'(indexBaseReg +
                {4'h0, instrWord[`SBX_INSTR_F_MSB:0]});
        end else if (instrWord[`SBX_INSTR_F_MSB:0] <= `SBX_IDX_LIMIT) begin
            effAddr = {`SBX_ACC_LOW_BANK,
                       instrWord[`SBX_INSTR_F_MSB:0]};
        end else begin
            effAddr = {`SBX_ACC_HIGH_BANK,
                       instrWord[`SBX_INSTR_F_MSB:0]};
        end
    end

    // ==========================================================
    // sequencer, register writes and flags
    always_comb begin
        stateNext = stateReg;
        opNext = opReg;
        fileAddrNext = fileAddrReg;
        destFileNext = destFileReg;
        operandNext = operandReg;
        resultNext = resultReg;
        resFlagsNext = resFlagsReg;
        workNext = workReg;
        bankSelectRegisterNext = bankSelectRegisterReg;
        ctrlNext = ctrlReg;
        indexBaseNext = indexBaseReg;
        flagsNext = flagsReg;
        timeoutFlagNext = timeoutFlagReg;
        powerDownFlagNext = powerDownFlagReg;
        retiredNext = 1'b0;
        watchdogClear = 1'b0;
        memWe = 1'b0;
        memAddr = busReq.addr[`SBX_FILE_AW-1:0];
        memData = busReq.wdata;
        // software goes first so that the instruction overrides it below
        if (busReq.wr) begin
            if (busReq.addr[`SBX_FILE_SEL_BIT]) begin
                memWe = 1'b1;
            end else if (busReq.addr == `SBX_REG_CTRL) begin
                ctrlNext = busReq.wdata;
            end else if (busReq.addr == `SBX_REG_BANK) begin
                bankSelectRegisterNext = busReq.wdata[`SBX_BANK_W-1:0];
            end else if (busReq.addr == `SBX_REG_WORK) begin
                workNext = busReq.wdata;
            end else if (busReq.addr == `SBX_REG_STATUS) begin
                flagsNext = busReq.wdata[`SBX_STAT_FLAGS_MSB:0];
            end else if (busReq.addr == `SBX_REG_IDXL) begin
                indexBaseNext[7:0] = busReq.wdata;
            end else if (busReq.addr == `SBX_REG_IDXH) begin
                indexBaseNext[`SBX_FILE_AW-1:8] = busReq.wdata[3:0];
            end
        end
        // a time-out clears the flag; a sleep setting it later wins
        if (watchdogTimeout) begin
            timeoutFlagNext = 1'b0;
        end
        case (stateReg)
            sbx_pkg::SBX_IDLE: begin
                if (instrValid) begin
                    opNext = decodedOp;
                    fileAddrNext = effAddr;
                    destFileNext = instrWord[`SBX_INSTR_D_BIT];
                    stateNext = sbx_pkg::SBX_Q2;
                end
            end
            sbx_pkg::SBX_Q2: begin
                if (opReg ==
                    sbx_pkg::SBX_OP_SUBTRACT_FILE_FROM_WORK_WITH_BORROW) begin
                    operandNext = fileMem[fileAddrReg];
                end
                stateNext = sbx_pkg::SBX_Q3;
            end
            sbx_pkg::SBX_Q3: begin
                if (opReg == sbx_pkg::SBX_OP_SLEEP) begin
                    watchdogClear = 1'b1;
                    timeoutFlagNext = 1'b1;
                    powerDownFlagNext = 1'b0;
                end else if (opReg ==
                    sbx_pkg::SBX_OP_SUBTRACT_FILE_FROM_WORK_WITH_BORROW) begin
                    resultNext = aluResult;
                    resFlagsNext = aluFlags;
                end
                stateNext = sbx_pkg::SBX_Q4;
            end
            sbx_pkg::SBX_Q4: begin
                retiredNext = 1'b1;
                stateNext = sbx_pkg::SBX_IDLE;
                if (opReg == sbx_pkg::SBX_OP_SLEEP) begin
                    stateNext = sbx_pkg::SBX_SLEEP;
                end else if (opReg ==
                    sbx_pkg::SBX_OP_SUBTRACT_FILE_FROM_WORK_WITH_BORROW) begin
                    flagsNext = resFlagsReg;
                    if (destFileReg) begin
                        memWe = 1'b1;
                        memAddr = fileAddrReg;
                        memData = resultReg;
                    end else begin
                        workNext = resultReg;
                    end
                end
            end
            sbx_pkg::SBX_SLEEP: begin
                // the time-out flag was already cleared above
                if (watchdogTimeout || wakeLevelReg) begin
                    stateNext = sbx_pkg::SBX_IDLE;
                end
            end
            default: begin
                stateNext = sbx_pkg::SBX_IDLE;
            end
        endcase
        sleepingNext = (stateNext == sbx_pkg::SBX_SLEEP);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= sbx_pkg::SBX_IDLE;
            opReg <= sbx_pkg::SBX_OP_NONE;
            fileAddrReg <= `SBX_RST_INDEX;
            destFileReg <= 1'b0;
            operandReg <= `SBX_RST_BYTE;
            resultReg <= `SBX_RST_BYTE;
            resFlagsReg <= '0;
            workReg <= `SBX_RST_BYTE;
            bankSelectRegisterReg <= `SBX_RST_BANK;
            ctrlReg <= `SBX_RST_BYTE;
            indexBaseReg <= `SBX_RST_INDEX;
            flagsReg <= '0;
            timeoutFlagReg <= `SBX_RST_TIMEOUT_FLAG;
            powerDownFlagReg <= `SBX_RST_POWER_DOWN_FLAG;
            sleepingReg <= 1'b0;
            retiredReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            opReg <= opNext;
            fileAddrReg <= fileAddrNext;
            destFileReg <= destFileNext;
            operandReg <= operandNext;
            resultReg <= resultNext;
            resFlagsReg <= resFlagsNext;
            workReg <= workNext;
            bankSelectRegisterReg <= bankSelectRegisterNext;
            ctrlReg <= ctrlNext;
            indexBaseReg <= indexBaseNext;
            flagsReg <= flagsNext;
            timeoutFlagReg <= timeoutFlagNext;
            powerDownFlagReg <= powerDownFlagNext;
            sleepingReg <= sleepingNext;
            retiredReg <= retiredNext;
        end
    end

    // file memory carries data only, so it is left out of reset
    always_ff @(posedge clk) begin
        if (memWe) begin
            fileMem[memAddr] <= memData;
        end
    end

    // ==========================================================
    // register port read data
    always_comb begin
        statusByte = '0;
        statusByte[`SBX_STAT_FLAGS_MSB:0] = flagsReg;
        statusByte[`SBX_STAT_POWER_DOWN_BIT] = powerDownFlagReg;
        statusByte[`SBX_STAT_TIMEOUT_BIT] = timeoutFlagReg;
        statusByte[`SBX_STAT_SLEEPING_BIT] = sleepingReg;
        rdataNext = '0;
        if (busReq.rd) begin
            if (busReq.addr[`SBX_FILE_SEL_BIT]) begin
                rdataNext = fileMem[busReq.addr[`SBX_FILE_AW-1:0]];
            end else if (busReq.addr == `SBX_REG_CTRL) begin
                rdataNext = ctrlReg;
            end else if (busReq.addr == `SBX_REG_BANK) begin
                rdataNext = `SBX_DATA_W'(bankSelectRegisterReg);
            end else if (busReq.addr == `SBX_REG_WORK) begin
                rdataNext = workReg;
            end else if (busReq.addr == `SBX_REG_STATUS) begin
                rdataNext = statusByte;
            end else if (busReq.addr == `SBX_REG_WDOG) begin
                rdataNext = `SBX_DATA_W'(watchdogCounter);
            end else if (busReq.addr == `SBX_REG_IDXL) begin
                rdataNext = indexBaseReg[7:0];
            end else if (busReq.addr == `SBX_REG_IDXH) begin
                rdataNext = {4'h0, indexBaseReg[`SBX_FILE_AW-1:8]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdataReg <= `SBX_RST_BYTE;
        end else begin
            rdataReg <= rdataNext;
        end
    end

    // ==========================================================
    // outputs
    assign instrReady = (stateReg == sbx_pkg::SBX_IDLE);
    assign retired = retiredReg;
    assign busRdata = rdataReg;
    assign sleeping = sleepingReg;
    assign oscRunning = ~sleepingReg;

endmodule : sbx_exec

`default_nettype wire

/* tb/sbx_exec_checker.sv */
// port assertions for the sleep and borrow-subtract core
// assumes a bind to sbx_exec and one core clock
`include "sbx_params.svh"
`default_nettype none

module sbx_exec_checker #(
    parameter int WDOG_POST_W = 4, // postscaler width
    parameter int WDOG_CNT_W = 8 // counter width
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic instrValid, // instruction offered
    input wire logic [`SBX_INSTR_W-1:0] instrWord, // instruction
    input wire logic instrReady, // core idle
    input wire logic retired, // retire pulse
    input wire sbx_pkg::sbx_bus_req_t busReq, // register request
    input wire logic [`SBX_DATA_W-1:0] busRdata, // read data
    input wire logic wakePin, // external wake
    input wire logic sleeping, // low-power state
    input wire logic oscRunning // oscillator enable
);
    logic taken;
    logic isSleep;
    logic statRd;
    assign taken = instrValid && instrReady;
    assign isSleep = instrWord == `SBX_OPC_SLEEP;
    assign statRd = busReq.rd && busReq.addr == `SBX_REG_STATUS;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // assertions
    osc_track_a: assert property (oscRunning == !sleeping)
        else $error("oscillator enable disagrees with sleeping");
    retire_delay_a: assert property (
        taken |=> !retired [*3] ##1 retired)
        else $error("retire pulse not four cycles after take");
    busy_quarters_a: assert property (
        taken |=> !instrReady [*3])
        else $error("instruction taken inside a busy sequence");
    sleep_entry_a: assert property (
        taken && isSleep |-> ##4 sleeping)
        else $error("low-power state not entered after Q4");
    no_sleep_other_a: assert property (
        taken && !isSleep |-> ##4 !sleeping && instrReady)
        else $error("non-sleep instruction stopped the core");
    stat_sleep_bit_a: assert property (
        statRd |=> busRdata[7] == $past(sleeping))
        else $error("status sleeping bit wrong");
    pd_clear_a: assert property (
        statRd && sleeping |=> !busRdata[5])
        else $error("power-down flag set while sleeping");
    ready_sleep_a: assert property (sleeping |-> !instrReady)
        else $error("core ready while sleeping");
    wake_ready_a: assert property ($fell(sleeping) |-> instrReady)
        else $error("core not ready after wake");
    pin_wake_a: assert property (
        (sleeping && wakePin) ##1 wakePin [*5] |-> !sleeping)
        else $error("wake pin did not wake the core");
    cov_sleep: cover property (taken && isSleep);
    cov_sub: cover property (taken && instrWord[15:10] == `SBX_OPC_SUBB_HI);
    cov_wake: cover property ($fell(sleeping));
endmodule : sbx_exec_checker

bind sbx_exec sbx_exec_checker #(.WDOG_POST_W(WDOG_POST_W),
    .WDOG_CNT_W(WDOG_CNT_W)) chk_u (.clk(clk), .rst_n(rst_n),
    .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .retired(retired), .busReq(busReq),
    .busRdata(busRdata), .wakePin(wakePin), .sleeping(sleeping),
    .oscRunning(oscRunning));

`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the execution core
// assumes sbx_exec with the watchdog shortened to 8 cycles
`include "sbx_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic instrValid;
    logic [15:0] instrWord;
    logic instrReady;
    logic retired;
    sbx_pkg::sbx_bus_req_t busReq;
    logic [7:0] busRdata;
    logic wakePin;
    logic sleeping;
    logic oscRunning;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    sbx_exec #(.WDOG_POST_W(1), .WDOG_CNT_W(2)) dut_u (.clk(clk),
        .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
        .instrReady(instrReady), .retired(retired), .busReq(busReq),
        .busRdata(busRdata), .wakePin(wakePin), .sleeping(sleeping),
        .oscRunning(oscRunning));

    // ==========================================================
    // clock, hang guard, tasks
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    // one idle cycle after each access keeps the strobes single-driven
    task automatic wr(logic [12:0] a, logic [7:0] d);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(logic [12:0] a, logic [7:0] exp, string what);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        busReq <= '0;
        #1 check8(what, exp, busRdata);
        @(posedge clk);
    endtask : rd
    task automatic exec(logic [15:0] w);
        instrValid <= 1'b1;
        instrWord <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check8("retired", 8'h01, {7'h00, retired});
    endtask : exec
    task automatic wait_wake(int lim);
        int n;
        n = 0;
        while (sleeping !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        check8("sleeping", 8'h00, {7'h00, sleeping});
    endtask : wait_wake
    task automatic sub_case(logic [7:0] w, logic [7:0] f, logic c,
                            logic d, logic a, logic [7:0] fa,
                            logic [11:0] loc);
        logic [8:0] full;
        logic [4:0] lo;
        logic [7:0] r;
        full = {1'b0, w} + {1'b0, ~f} + 9'(c);
        lo = {1'b0, w[3:0]} + {1'b0, ~f[3:0]} + 5'(c);
        r = full[7:0];
        wr(`SBX_REG_WORK, w);
        wr({1'b1, loc}, f);
        wr(`SBX_REG_STATUS, {7'h00, c});
        exec({6'h15, d, a, fa});
        rd(`SBX_REG_WORK, d ? w : r, "work");
        rd({1'b1, loc}, d ? r : f, "file");
        rd(`SBX_REG_STATUS, {3'b011, r[7], (w[7] != f[7]) &&
            (r[7] != w[7]), r == 8'h00, lo[4], full[8]}, "status");
    endtask : sub_case

    // ==========================================================
    // sequence
    initial begin
        rst_n = 1'b0;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        busReq = '0;
        wakePin = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`SBX_REG_STATUS, 8'h60, "status");
        rd(13'h0007, 8'h00, "unmapped");
        wr(`SBX_REG_BANK, 8'h02);
        wr(`SBX_REG_IDXL, 8'h20);
        wr(`SBX_REG_IDXH, 8'h03);
        sub_case(8'h02, 8'h03, 1'b1, 1'b1, 1'b1, 8'h10, 12'h210);
        sub_case(8'h05, 8'h02, 1'b1, 1'b0, 1'b1, 8'h10, 12'h210);
        sub_case(8'h03, 8'h02, 1'b0, 1'b1, 1'b0, 8'h80, 12'hf80);
        sub_case(8'h80, 8'h01, 1'b1, 1'b0, 1'b0, 8'h5f, 12'h05f);
        wr(`SBX_REG_CTRL, 8'h01);
        sub_case(8'h10, 8'h01, 1'b0, 1'b1, 1'b0, 8'h10, 12'h330);
        sub_case(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 8'h60, 12'hf60);
        sub_case(8'h40, 8'h30, 1'b1, 1'b1, 1'b0, 8'h5f, 12'h37f);
        wr(`SBX_REG_CTRL, 8'h00);
        wr(`SBX_REG_STATUS, 8'h15);
        exec(16'h0000);
        exec(`SBX_OPC_SLEEP);
        check8("osc", 8'h00, {7'h00, oscRunning});
        rd(`SBX_REG_STATUS, 8'hd5, "status");
        wakePin <= 1'b1;
        wait_wake(20);
        @(posedge clk);
        wakePin <= 1'b0;
        rd(`SBX_REG_STATUS, 8'h55, "status");
        wr(`SBX_REG_CTRL, 8'h02);
        repeat (10) @(posedge clk);
        rd(`SBX_REG_STATUS, 8'h15, "status");
        exec(`SBX_OPC_SLEEP);
        rd(`SBX_REG_WDOG, 8'h00, "watchdog");
        rd(`SBX_REG_STATUS, 8'hd5, "status");
        wait_wake(12);
        rd(`SBX_REG_STATUS, 8'h15, "status");
        results();
    end
endmodule : tb

`default_nettype wire
